// ==== src/fcr_top.sv ====
// read configuration registers and fast read sequencer of a serial flash
`default_nettype none

// ========================================
// Contract
// - fast reads wait the dummy count of volatile bits 7:4.
// - dummy codes 0000 and 1111 both give the default count.
// - volatile bit 3 at 0 enables execute-in-place, 1 is default.
// - wrap bits 1:0 pick 16, 32, 64 byte wrap or sequential.
// - a wrap burst starts at the given address and wraps its block.
// - volatile values act at once and change only by command.
// - the nonvolatile register changes only by its own commands; here resetn also reloads it with the factory value 16'hffff.
// - at power-on nonvolatile bits 3:2 choose quad or dual protocol.
// - nonvolatile bits 15:12 hold the power-on dummy count, all ones.
// - nonvolatile bit 3 quad, bit 2 dual, both active low.

module fcr_top (
    // clock, reset and enable
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // power-cycle event
    input  wire logic        boot,
    // command port
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_op,
    input  wire logic [23:0] cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        cmd_stop,
    output logic             cmd_ready,
    // register read answer
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    // array read address stream
    input  wire logic        rd_ready,
    output logic             rd_valid,
    output logic [23:0]      rd_addr,
    // configuration for the rest of the device
    output logic [1:0]       proto,
    output logic             execute_in_place_mode_n
);
    // ========================================
    // state
    fcr_pkg::fcr_state_e state_reg;
    fcr_pkg::fcr_state_e state_next;
    logic [3:0]          dummy_reg;
    logic [3:0]          dummy_next;
    logic [23:0]         start_reg;
    logic [23:0]         start_next;
    logic [7:0]          vcfg_reg;
    logic [7:0]          vcfg_next;
    logic [15:0]         nvcfg_reg;
    logic [15:0]         nvcfg_next;
    logic [1:0]          proto_reg;
    logic [1:0]          proto_next;
    logic                cmd_ready_reg;
    logic                cmd_ready_next;
    logic                rsp_valid_reg;
    logic                rsp_valid_next;
    logic [15:0]         rsp_data_reg;
    logic [15:0]         rsp_data_next;
    logic                rd_valid_reg;
    logic                rd_valid_next;
    logic [23:0]         rd_addr_reg;
    logic [23:0]         rd_addr_next;

    logic                acc;
    logic                fr_acc;
    logic                wv_acc;
    logic                wn_acc;
    logic                flush;
    logic                drain_ok;
    logic                start_burst;
    logic [3:0]          dummy_code;
    logic [3:0]          dummy_eff;
    logic                fifo_valid;
    logic                fifo_in_ready;
    logic [23:0]         fifo_data;

    fcr_burst_if bif ();

    // ========================================
    // decode
    function automatic logic [1:0] proto_of(input logic [15:0] nv);
        if (!nv[fcr_pkg::NV_QUAD_BIT])
            return fcr_pkg::PROTO_QUAD;
        else if (!nv[fcr_pkg::NV_DUAL_BIT])
            return fcr_pkg::PROTO_DUAL;
        else
            return fcr_pkg::PROTO_EXT;
    endfunction

    assign acc    = cmd_valid && cmd_ready_reg && !boot;
    assign fr_acc = acc && cmd_op == fcr_pkg::OP_FAST_READ;
    assign wv_acc = acc && cmd_op == fcr_pkg::OP_WR_VCFG;
    assign wn_acc = acc && cmd_op == fcr_pkg::OP_WR_NVCFG;
    assign flush  = cmd_stop || boot;

    assign dummy_code = vcfg_reg[fcr_pkg::VCFG_DUMMY_LSB +: 4];
    // both end codes mean the setting that is safe at the top clock rate
    assign dummy_eff = (dummy_code == fcr_pkg::DUMMY_CODE_LO ||
                        dummy_code == fcr_pkg::DUMMY_CODE_HI)
                       ? fcr_pkg::DUMMY_DEFAULT : dummy_code;

    // the last dummy cycle launches the burst
    assign start_burst = state_reg == fcr_pkg::ST_DUMMY &&
                         dummy_reg == 4'h1 && !flush;

    // ========================================
    // burst generator and address fifo
    assign bif.start      = start_burst;
    assign bif.stop       = flush;
    assign bif.start_addr = start_reg;
    // wrap is read live, but writes are taken only in idle, so a running burst keeps its wrap
    assign bif.wrap       = vcfg_reg[fcr_pkg::VCFG_WRAP_LSB +: 2];
    assign bif.ready      = fifo_in_ready;

    fcr_burst u_burst (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .bif    (bif.gen)
    );

    fcr_fifo #(
        .WIDTH (fcr_pkg::ADDR_W),
        .DEPTH (fcr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .ce        (ce),
        .flush     (flush),
        .in_valid  (bif.valid),
        .in_ready  (fifo_in_ready),
        .in_data   (bif.addr),
        .out_valid (fifo_valid),
        .out_ready (drain_ok),
        .out_data  (fifo_data)
    );

    assign drain_ok = (!rd_valid_reg || rd_ready) && !flush;

    // ========================================
    // next state
    always_comb
    begin
        state_next     = state_reg;
        dummy_next     = dummy_reg;
        start_next     = start_reg;
        vcfg_next      = vcfg_reg;
        nvcfg_next     = nvcfg_reg;
        proto_next     = proto_reg;
        rsp_valid_next = 1'b0;
        rsp_data_next  = rsp_data_reg;
        case (state_reg)
            fcr_pkg::ST_IDLE:
            begin
                if (fr_acc)
                begin
                    state_next = fcr_pkg::ST_DUMMY;
                    dummy_next = dummy_eff;
                    start_next = cmd_addr;
                end
            end
            fcr_pkg::ST_DUMMY:
            begin
                if (cmd_stop)
                    state_next = fcr_pkg::ST_IDLE;
                else if (dummy_reg == 4'h1)
                    state_next = fcr_pkg::ST_BURST;
                else
                    dummy_next = dummy_reg - 4'h1;
            end
            fcr_pkg::ST_BURST:
            begin
                if (cmd_stop)
                    state_next = fcr_pkg::ST_IDLE;
            end
            default:
                state_next = fcr_pkg::ST_IDLE;
        endcase

        // registers move only through their own commands
        if (wv_acc)
            vcfg_next = {cmd_wdata[7:3], 1'b0, cmd_wdata[1:0]};
        if (wn_acc && nvcfg_reg[fcr_pkg::NV_LOCK_BIT])
            nvcfg_next = cmd_wdata;
        if (acc && cmd_op == fcr_pkg::OP_RD_VCFG)
        begin
            rsp_valid_next = 1'b1;
            rsp_data_next  = {8'h00, vcfg_reg};
        end
        if (acc && cmd_op == fcr_pkg::OP_RD_NVCFG)
        begin
            rsp_valid_next = 1'b1;
            rsp_data_next  = nvcfg_reg;
        end

        // a power cycle reloads dummy count, execute-in-place and protocol from the stored ones, and sets wrap to sequential
        if (boot)
        begin
            state_next = fcr_pkg::ST_IDLE;
            vcfg_next  = {nvcfg_reg[fcr_pkg::NV_DUMMY_LSB +: 4],
                          nvcfg_reg[fcr_pkg::NV_XIP_LSB +: 3] ==
                          fcr_pkg::NV_XIP_OFF,
                          1'b0, fcr_pkg::WRAP_SEQ};
            proto_next = proto_of(nvcfg_reg);
        end
        cmd_ready_next = state_next == fcr_pkg::ST_IDLE;
    end

    always_comb
    begin
        rd_valid_next = rd_valid_reg;
        rd_addr_next  = rd_addr_reg;
        if (flush)
            rd_valid_next = 1'b0;
        else if (fifo_valid && drain_ok)
        begin
            rd_valid_next = 1'b1;
            rd_addr_next  = fifo_data;
        end
        else if (rd_ready)
            rd_valid_next = 1'b0;
    end

    // ========================================
    // registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg     <= fcr_pkg::ST_IDLE;
            dummy_reg     <= 4'h0;
            start_reg     <= 24'h000000;
            vcfg_reg      <= fcr_pkg::VCFG_RESET;
            nvcfg_reg     <= fcr_pkg::NVCFG_RESET;
            proto_reg     <= fcr_pkg::PROTO_EXT;
            cmd_ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= 16'h0000;
            rd_valid_reg  <= 1'b0;
            rd_addr_reg   <= 24'h000000;
        end
        else if (ce)
        begin
            state_reg     <= state_next;
            dummy_reg     <= dummy_next;
            start_reg     <= start_next;
            vcfg_reg      <= vcfg_next;
            nvcfg_reg     <= nvcfg_next;
            proto_reg     <= proto_next;
            cmd_ready_reg <= cmd_ready_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg  <= rsp_data_next;
            rd_valid_reg  <= rd_valid_next;
            rd_addr_reg   <= rd_addr_next;
        end
    end

    assign cmd_ready = cmd_ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_data  = rsp_data_reg;
    assign rd_valid  = rd_valid_reg;
    assign rd_addr   = rd_addr_reg;
    assign proto     = proto_reg;
    // 0 enables, so the pin-level sense is kept as stored
    assign execute_in_place_mode_n = vcfg_reg[fcr_pkg::VCFG_XIP_BIT];

    // ========================================
    // checks
    logic [3:0] dseen_reg;
    logic [3:0] dload_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dseen_reg <= 4'h0;
            dload_reg <= 4'h0;
        end
        else if (ce)
        begin
            if (fr_acc)
            begin
                dseen_reg <= 4'h0;
                dload_reg <= dummy_eff;
            end
            else if (state_reg == fcr_pkg::ST_DUMMY)
                dseen_reg <= dseen_reg + 4'h1;
        end
    end

    property p_dummy_len;
        @(posedge clk) disable iff (!resetn || !ce)
        start_burst |-> dseen_reg + 4'h1 == dload_reg;
    endproperty
    a_dummy_len: assert property (p_dummy_len)
        else $error("dummy phase length differs from the count");

    sequence s_fr_default;
        fr_acc && (dummy_code == 4'h0 || dummy_code == 4'hf);
    endsequence
    sequence s_in_dummy;
        state_reg == fcr_pkg::ST_DUMMY && dummy_reg == 4'ha;
    endsequence
    property p_dummy_default;
        @(posedge clk) disable iff (!resetn || !ce)
        s_fr_default |=> s_in_dummy;
    endproperty
    a_dummy_default: assert property (p_dummy_default)
        else $error("end dummy code did not give the default count");

    property p_xip_write;
        @(posedge clk) disable iff (!resetn || !ce)
        wv_acc |=> execute_in_place_mode_n == $past(cmd_wdata[3]);
    endproperty
    a_xip_write: assert property (p_xip_write)
        else $error("execute-in-place bit not written");

    property p_vcfg_only_cmd;
        @(posedge clk) disable iff (!resetn || !ce)
        (!wv_acc && !boot) |=> $stable(vcfg_reg);
    endproperty
    a_vcfg_only_cmd: assert property (p_vcfg_only_cmd)
        else $error("volatile register changed without a command");

    property p_wrap_live;
        @(posedge clk) disable iff (!resetn || !ce)
        wv_acc |=> bif.wrap == $past(cmd_wdata[1:0]);
    endproperty
    a_wrap_live: assert property (p_wrap_live)
        else $error("wrap setting did not act at once");

    property p_nv_only_cmd;
        @(posedge clk) disable iff (!resetn || !ce)
        !wn_acc |=> $stable(nvcfg_reg);
    endproperty
    a_nv_only_cmd: assert property (p_nv_only_cmd)
        else $error("nonvolatile register changed without a command");

    property p_proto_boot;
        @(posedge clk) disable iff (!resetn || !ce)
        boot |=> proto_reg == ($past(nvcfg_reg[3]) == 1'b0 ? 2'b10 :
                               $past(nvcfg_reg[2]) == 1'b0 ? 2'b01 : 2'b00);
    endproperty
    a_proto_boot: assert property (p_proto_boot)
        else $error("protocol not taken from nonvolatile bits");

    property p_boot_dummy;
        @(posedge clk) disable iff (!resetn || !ce)
        boot |=> vcfg_reg[7:4] == $past(nvcfg_reg[15:12]);
    endproperty
    a_boot_dummy: assert property (p_boot_dummy)
        else $error("power-on dummy count not loaded");
endmodule

`default_nettype wire

// ==== pkg/fcr_pkg.sv ====
// constants and types of the flash read configuration register block
`default_nettype none

package fcr_pkg;
    // ========================================
    // widths
    localparam int ADDR_W     = 24;
    localparam int VCFG_W     = 8;
    localparam int NVCFG_W    = 16;
    localparam int FIFO_DEPTH = 8;

    // ========================================
    // volatile register layout and reset value
    localparam int              VCFG_DUMMY_LSB = 4;
    localparam int              VCFG_XIP_BIT   = 3;
    localparam int              VCFG_WRAP_LSB  = 0;
    localparam logic [7:0]      VCFG_RESET     = 8'hfb;

    // ========================================
    // nonvolatile register layout and factory value
    localparam int              NV_DUMMY_LSB = 12;
    localparam int              NV_XIP_LSB   = 9;
    localparam int              NV_QUAD_BIT  = 3;
    localparam int              NV_DUAL_BIT  = 2;
    localparam int              NV_LOCK_BIT  = 0;
    localparam logic [2:0]      NV_XIP_OFF   = 3'h7;
    localparam logic [15:0]     NVCFG_RESET  = 16'hffff;

    // ========================================
    // dummy cycle codes
    localparam logic [3:0]      DUMMY_CODE_LO = 4'h0;
    localparam logic [3:0]      DUMMY_CODE_HI = 4'hf;
    localparam logic [3:0]      DUMMY_DEFAULT = 4'ha;

    // ========================================
    // wrap masks on the low address bits
    localparam logic [5:0]      WRAP_MASK_16 = 6'h0f;
    localparam logic [5:0]      WRAP_MASK_32 = 6'h1f;
    localparam logic [5:0]      WRAP_MASK_64 = 6'h3f;

    typedef enum logic [1:0] {
        WRAP_16  = 2'b00,
        WRAP_32  = 2'b01,
        WRAP_64  = 2'b10,
        WRAP_SEQ = 2'b11
    } fcr_wrap_e;

    typedef enum logic [1:0] {
        PROTO_EXT  = 2'b00,
        PROTO_DUAL = 2'b01,
        PROTO_QUAD = 2'b10
    } fcr_proto_e;

    typedef enum logic [2:0] {
        OP_NONE      = 3'b000,
        OP_RD_VCFG   = 3'b001,
        OP_WR_VCFG   = 3'b010,
        OP_RD_NVCFG  = 3'b011,
        OP_WR_NVCFG  = 3'b100,
        OP_FAST_READ = 3'b101
    } fcr_op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DUMMY = 2'b01,
        ST_BURST = 2'b10
    } fcr_state_e;
endpackage

`default_nettype wire

// ==== pkg/fcr_burst_if.sv ====
// link between the read sequencer and the burst address generator
`default_nettype none

interface fcr_burst_if;
    logic                      start;
    logic                      stop;
    logic [fcr_pkg::ADDR_W-1:0] start_addr;
    logic [1:0]                wrap;
    logic                      valid;
    logic                      ready;
    logic [fcr_pkg::ADDR_W-1:0] addr;

    modport ctl (output start, stop, start_addr, wrap, ready,
                 input  valid, addr);
    modport gen (input  start, stop, start_addr, wrap, ready,
                 output valid, addr);
endinterface

`default_nettype wire

// ==== src/fcr_fifo.sv ====
// flip-flop fifo with valid and ready on both sides
`default_nettype none

module fcr_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock, reset and enable
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wp_reg;
    logic [AW:0]      wp_next;
    logic [AW:0]      rp_reg;
    logic [AW:0]      rp_next;
    logic             push;
    logic             pop;

    assign in_ready  = (wp_reg - rp_reg) != FULL;
    assign out_valid = wp_reg != rp_reg;
    assign out_data  = mem_reg[rp_reg[AW-1:0]];
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    always_comb
    begin
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
        if (flush)
        begin
            wp_next = '0;
            rp_next = '0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
        end
        else if (ce)
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
    end

    // data entries carry no reset: only pointers define what is valid
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge clk)
        begin
            if (ce && push && wp_reg[AW-1:0] == AW'(i))
                mem_reg[i] <= in_data;
        end
    end

    property p_fifo_fills;
        @(posedge clk) disable iff (!resetn || !ce)
        (push && !pop && (wp_reg - rp_reg) == FULL - 1'b1) |=> !in_ready;
    endproperty
    a_fifo_fills: assert property (p_fifo_fills)
        else $error("fifo did not report full");
endmodule

`default_nettype wire

// ==== src/fcr_burst.sv ====
// address generator for wrapped and sequential read bursts
`default_nettype none

module fcr_burst (
    // clock, reset and enable
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // control in, address stream out
    fcr_burst_if.gen  bif
);
    logic        busy_reg;
    logic        busy_next;
    logic [23:0] addr_reg;
    logic [23:0] addr_next;
    logic [5:0]  mask;
    logic [5:0]  low_inc;
    logic        step;

    assign bif.valid = busy_reg;
    assign bif.addr  = addr_reg;
    assign step      = busy_reg && bif.ready && !bif.start && !bif.stop;
    assign low_inc   = addr_reg[5:0] + 6'h01;

    always_comb
    begin
        case (bif.wrap)
            fcr_pkg::WRAP_16: mask = fcr_pkg::WRAP_MASK_16;
            fcr_pkg::WRAP_32: mask = fcr_pkg::WRAP_MASK_32;
            fcr_pkg::WRAP_64: mask = fcr_pkg::WRAP_MASK_64;
            default:          mask = fcr_pkg::WRAP_MASK_64;
        endcase
        busy_next = busy_reg;
        addr_next = addr_reg;
        if (bif.start)
        begin
            busy_next = 1'b1;
            addr_next = bif.start_addr;
        end
        else if (bif.stop)
            busy_next = 1'b0;
        else if (step && bif.wrap == fcr_pkg::WRAP_SEQ)
            addr_next = addr_reg + 24'h000001;
        else if (step)
            addr_next = {addr_reg[23:6],
                         (addr_reg[5:0] & ~mask) | (low_inc & mask)};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_reg <= 1'b0;
            addr_reg <= 24'h000000;
        end
        else if (ce)
        begin
            busy_reg <= busy_next;
            addr_reg <= addr_next;
        end
    end

    property p_wrap16_turns;
        @(posedge clk) disable iff (!resetn || !ce)
        (step && bif.wrap == fcr_pkg::WRAP_16 && addr_reg[3:0] == 4'hf)
        |=> addr_reg[3:0] == 4'h0 && addr_reg[23:4] == $past(addr_reg[23:4]);
    endproperty
    a_wrap16_turns: assert property (p_wrap16_turns)
        else $error("16-byte wrap left its block");

    property p_seq_carries;
        @(posedge clk) disable iff (!resetn || !ce)
        (step && bif.wrap == fcr_pkg::WRAP_SEQ && addr_reg[5:0] == 6'h3f)
        |=> addr_reg == $past(addr_reg) + 24'h000001;
    endproperty
    a_seq_carries: assert property (p_seq_carries)
        else $error("sequential read did not cross the block");
endmodule

`default_nettype wire

// ==== sim/fcr_reader.sv ====
// array-side consumer of read addresses, with optional stalls
`default_nettype none

module fcr_reader (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // 0 always ready, 1 random stalls, 2 held off
    input  wire logic [1:0] mode,
    // address stream
    output logic            rd_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 4;

    // held off long enough to fill the fifo and stall the generator
    always @(posedge clk or negedge resetn)
        if (!resetn)
            rd_ready <= 1'b0;
        else
            rd_ready <= (mode == 2'h0) ||
                        (mode == 2'h1 && ($random(seed) & 1) == 0);
endmodule

`default_nettype wire

// ==== sim/fcr_top_bench.sv ====
// self-checking bench of the read configuration registers
`default_nettype none

module fcr_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    logic        boot = 1'b0;
    logic        cmd_valid = 1'b0;
    logic [2:0]  cmd_op = 3'h0;
    logic [23:0] cmd_addr = 24'h0;
    logic [15:0] cmd_wdata = 16'h0;
    logic        cmd_stop = 1'b0;
    logic        cmd_ready, rsp_valid, rd_ready, rd_valid, eip_n;
    logic [15:0] rsp_data, nv;
    logic [23:0] rd_addr;
    logic [1:0]  proto;
    logic [1:0]  mode = 2'h0;
    logic [7:0]  v;
    logic [3:0]  codes [6] = '{4'h0, 4'hf, 4'h1, 4'h3, 4'ha, 4'h7};
    int          err_count = 0;
    int          n_compared = 0;
    int          seed = 4;
    int          cycles = 0;

    fcr_top dut (.clk, .resetn, .ce, .boot, .cmd_valid, .cmd_op, .cmd_addr,
        .cmd_wdata, .cmd_stop, .cmd_ready, .rsp_valid, .rsp_data,
        .rd_ready, .rd_valid, .rd_addr, .proto,
        .execute_in_place_mode_n(eip_n));
    fcr_reader far (.clk, .resetn, .mode, .rd_ready);

    initial
        forever #10 clk = ~clk;

    // ========================================
    // expectations
    function automatic int dummy_of(logic [3:0] c);
        return (c == 4'h0 || c == 4'hf) ? 10 : int'(c);
    endfunction

    function automatic logic [23:0] next_addr(logic [23:0] a, logic [1:0] w);
        logic [23:0] m;
        m = (w == 2'h3) ? 24'hffffff : 24'((16 << w) - 1);
        return (a & ~m) | ((a + 24'h1) & m);
    endfunction

    // ========================================
    // drivers and checks
    task automatic check(input logic [23:0] got, exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic issue(input logic [2:0] op, input logic [23:0] a,
                         input logic [15:0] d);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_wdata <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 100);
        cmd_valid <= 1'b0;
        check(24'(cmd_ready), 24'h1, "command taken");
    endtask

    task automatic rd_reg(input logic [2:0] op, input logic [15:0] exp);
        issue(op, 24'h0, 16'h0);
        @(negedge clk);
        check(24'({rsp_valid, rsp_data}), 24'({1'b1, exp}),
              "reg read");
    endtask

    task automatic fast_read(input logic [3:0] c, input logic [1:0] w, m,
                             input logic [23:0] a);
        logic [23:0] e;
        int n;
        int k;
        e = a;
        issue(3'h2, 24'h0, 16'({c, 2'b10, w}));
        mode <= m;
        issue(3'h5, e, 16'h0);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (rd_valid !== 1'b1 && n < 40);
        check(24'(n), 24'(dummy_of(c) + 3), "dummy wait");
        if (m == 2'h2)
            repeat (20) @(posedge clk);
        mode <= 2'h1;
        k = 0;
        while (k < 24 && n < 400)
        begin
            @(posedge clk);
            n++;
            if (rd_valid === 1'b1 && rd_ready === 1'b1)
            begin
                check(rd_addr, e, "burst address");
                e = next_addr(e, w);
                k++;
            end
        end
        // a stalled or hung stream must not end the burst quietly
        check(24'(k), 24'h18, "burst length");
        cmd_stop <= 1'b1;
        @(posedge clk);
        cmd_stop <= 1'b0;
        @(negedge clk);
        check(24'({rd_valid, cmd_ready}), 24'h1,
              "frame end");
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ========================================
    // sequence
    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd_reg(3'h1, 16'h00fb);
        rd_reg(3'h3, 16'hffff);
        check(24'({proto, eip_n}), 24'h1, "reset outputs");
        repeat (6)
        begin
            v = 8'($random(seed));
            issue(3'h2, 24'h0, 16'(v));
            issue(3'h6, 24'h0, 16'hffff);
            rd_reg(3'h1, 16'(v & 8'hfb));
            check(24'(eip_n), 24'(v[3]), "exec in place");
        end
        // a low enable must hold the volatile register through a pending write
        @(posedge clk);
        ce <= 1'b0;
        cmd_valid <= 1'b1;
        cmd_op <= 3'h2;
        cmd_wdata <= 16'(~v);
        repeat (4) @(posedge clk);
        cmd_valid <= 1'b0;
        ce <= 1'b1;
        rd_reg(3'h1, 16'(v & 8'hfb));
        // codes 3 and 10 are the least that suit the top clock rate
        for (int i = 0; i < 6; i++)
            fast_read(codes[i], 2'(i), 2'(i % 3),
                      24'($random(seed)));
        // sequential burst across a block end and the top of the array
        fast_read(4'h3, 2'h3, 2'h0, 24'hfffff0);
        for (int i = 0; i < 4; i++)
        begin
            nv = {4'($random(seed)), 3'h7, 5'h1f, 2'(i), 2'h3};
            issue(3'h4, 24'h0, nv);
            @(posedge clk);
            boot <= 1'b1;
            @(posedge clk);
            boot <= 1'b0;
            rd_reg(3'h1, {8'h00, nv[15:12], 4'hb});
            check(24'(proto), (i < 2) ? 24'h2 : 24'(i == 2),
                  "protocol");
        end
        // a cleared lock bit must freeze the nonvolatile word
        issue(3'h4, 24'h0, 16'hfffe);
        issue(3'h4, 24'h0, 16'hffff);
        rd_reg(3'h3, 16'hfffe);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd_reg(3'h3, 16'hffff);
        report_and_stop();
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            report_and_stop();
        end
    end
endmodule

`default_nettype wire
